// file: pulse_load_defs.vh
// Purpose: Shared constants for the pulse-driven-load input monitor
// Assumes: 125 MHz ref_clk
// Notes: Times are in their own unit; cycle counts derive from them
`ifndef PULSE_LOAD_DEFS_VH
`define PULSE_LOAD_DEFS_VH

// Channel counts
`define N_GRP1 17
`define N_GRP2 4
`define N_GRP3 4
`define N_GRP4 7
`define N_BIP 2
`define N_FLEX 5
`define N_CHAN 39
`define N_CFG_CHAN 7
`define N_CABLE 5

// Widths
`define TS_W 32
`define CNT_W 16
`define ADC_W 12
`define ADC_CH_W 6
`define RAIL_W 4
`define DRV_W 2
`define CFG_CH_W 3

// Highest legal driver selection code
`define DRV_MAX 2'h2

// Error codes shown on the activity LED: general is steady on, the others blink
`define ERR_GENERAL 2'h0
`define ERR_UNPROG 2'h1
`define ERR_WRONG_TYPE 2'h2
`define BLINKS_UNPROG 3'h2
`define BLINKS_WRONG_TYPE 3'h3
`define BLINK_PAUSE 4'h4

// Blink half period
`define CLK_MHZ 125
`define BLINK_HALF_MS 250
`define BLINK_HALF_CYC (`BLINK_HALF_MS * 1000 * `CLK_MHZ)

`endif

// file: pulse_load_channel.v
// Purpose: Pulse-driven-load monitor: edges, period, duty, analog, LEDs
// Assumes: Single 125 MHz clock, sense comparators arrive asynchronously
// Notes: Results of a step are presented after the next sync pulse
`timescale 1ns/1ps
`include "pulse_load_defs.vh"

module pulse_load_channel #(
  parameter [31:0] BLINK_HALF_CYC = `BLINK_HALF_CYC
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Sense comparator inputs
  input wire [`N_GRP1-1:0] std_group_one_inputs,
  input wire [`N_GRP2-1:0] std_group_two_inputs,
  input wire [`N_GRP3-1:0] std_group_three_inputs,
  input wire [`N_GRP4-1:0] std_group_four_inputs,
  input wire [`N_BIP-1:0] bipolar_inputs,
  input wire [`N_FLEX-1:0] flex_inputs,
  // Cable straps
  input wire [`N_CABLE-1:0] cable_code_inputs,
  // Converter results
  input wire adc_valid,
  input wire [`ADC_CH_W-1:0] adc_channel,
  input wire [`ADC_W-1:0] adc_data,
  // Step synchronisation from the chassis
  input wire step_sync,
  // Link with the host_step_unit
  input wire config_done,
  input wire link_reset,
  input wire cfg_write,
  input wire [`CFG_CH_W-1:0] cfg_channel,
  input wire [`RAIL_W-1:0] cfg_rails,
  input wire [`DRV_W-1:0] cfg_driver,
  input wire model_fault,
  input wire fault_clear,
  // Status from the board
  input wire over_voltage,
  input wire over_current,
  input wire logic_unprogrammed,
  input wire wrong_module_type,
  // Measurement results of the last step, and the live input levels
  output wire [`N_CHAN*`TS_W-1:0] period_out,
  output wire [`N_CHAN*`TS_W-1:0] high_time_out,
  output wire [`N_CHAN*`CNT_W-1:0] edge_count_out,
  output wire [`N_CHAN*`ADC_W-1:0] analog_out,
  output wire [`N_CHAN-1:0] level_out,
  output reg step_done_reg,
  // Applied configuration and reports
  output reg [`N_CFG_CHAN*`RAIL_W-1:0] rail_sel_reg,
  output reg [`N_CFG_CHAN*`DRV_W-1:0] driver_sel_reg,
  output reg cfg_error_reg,
  output reg sw_fault_reg,
  output reg [`N_CABLE-1:0] cable_code_reg,
  // LEDs
  output reg led_activity_reg,
  output reg led_fault_reg
);

  wire [`N_CHAN-1:0] raw_in, agree, rise, fall;
  reg [`N_CHAN-1:0] sync1_reg, sync2_reg, sync3_reg, level_reg;
  reg [`TS_W-1:0] ts_reg;
  reg [2:0] stp_sync_reg;
  reg stp_level_reg;
  wire step_pulse, cfg_bad, fault_any;
  reg [`N_CABLE-1:0] cab1_reg, cab2_reg, cab3_reg;
  reg [`ADC_W-1:0] adc_live [0:`N_CHAN-1];
  reg [2:0] flt1_reg, flt2_reg, flt3_reg, flt_reg;
  reg cfg1_reg, cfg2_reg, cfg3_reg, cfg_ok_reg, link_up_reg;
  reg [31:0] blink_cnt_reg;
  reg [3:0] phase_reg, phase_next;
  reg [2:0] blinks;
  reg [1:0] err_code;
  reg blink_on;
  integer i;
  // channel order group one..four, bipolar, flexible
  assign raw_in = {flex_inputs, bipolar_inputs, std_group_four_inputs,
                   std_group_three_inputs, std_group_two_inputs,
                   std_group_one_inputs};
  // three-stage synchroniser, first stage feeds only the second
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      {sync1_reg, sync2_reg, sync3_reg, level_reg} <= {(4*`N_CHAN){1'b0}};
      ts_reg <= {`TS_W{1'b0}};
    end
    else
    begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      level_reg <= (agree & sync3_reg) | (~agree & level_reg);
      // free-running timestamp, wraps; differences stay valid
      ts_reg <= ts_reg + {{(`TS_W-1){1'b0}}, 1'b1};
    end
  end
  // an edge counts once stages two and three agree
  assign agree = ~(sync2_reg ^ sync3_reg);
  assign rise = agree & sync3_reg & ~level_reg;
  assign fall = agree & ~sync3_reg & level_reg;
  // step sync is asynchronous to us, detect its rising edge
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      {stp_sync_reg, stp_level_reg, step_done_reg} <= 5'h00;
    else
    begin
      stp_sync_reg <= {stp_sync_reg[1:0], step_sync};
      if (stp_sync_reg[1] == stp_sync_reg[2])
        stp_level_reg <= stp_sync_reg[2];
      step_done_reg <= step_pulse;
    end
  end
  assign step_pulse = (stp_sync_reg[1] == stp_sync_reg[2]) &
                      stp_sync_reg[2] & ~stp_level_reg;

  // each channel measured by its own copy of the logic
  genvar g;
  generate
    for (g = 0; g < `N_CHAN; g = g + 1)
    begin : chan
      reg [`TS_W-1:0] last_rise_reg;
      reg [`TS_W-1:0] period_cur_reg;
      reg [`TS_W-1:0] high_cur_reg;
      reg [`CNT_W-1:0] count_cur_reg;
      reg [`TS_W-1:0] period_lat_reg;
      reg [`TS_W-1:0] high_lat_reg;
      reg [`CNT_W-1:0] count_lat_reg;
      reg [`ADC_W-1:0] adc_lat_reg;
      wire [`CNT_W-1:0] count_inc;
      assign count_inc = count_cur_reg +
                         {{(`CNT_W-1){1'b0}}, rise[g] | fall[g]};
      always @(posedge ref_clk or posedge rst)
      begin
        if (rst)
        begin
          {last_rise_reg, period_cur_reg, high_cur_reg} <= {(3*`TS_W){1'b0}};
          {period_lat_reg, high_lat_reg} <= {(2*`TS_W){1'b0}};
          {count_cur_reg, count_lat_reg} <= {(2*`CNT_W){1'b0}};
          adc_lat_reg <= {`ADC_W{1'b0}};
        end
        else
        begin
          // period rise to rise, high time rise to fall
          if (rise[g])
          begin
            last_rise_reg <= ts_reg;
            period_cur_reg <= ts_reg - last_rise_reg;
          end
          if (fall[g])
            high_cur_reg <= ts_reg - last_rise_reg;
          // latch step results, restart count; an edge in the
          // sync cycle opens the new step so none is lost
          if (step_pulse)
          begin
            period_lat_reg <= period_cur_reg;
            high_lat_reg <= high_cur_reg;
            count_lat_reg <= count_cur_reg;
            adc_lat_reg <= adc_live[g];
            count_cur_reg <= {{(`CNT_W-1){1'b0}}, rise[g] | fall[g]};
          end
          else
            count_cur_reg <= count_inc;
        end
      end
      assign period_out[g*`TS_W +: `TS_W] = period_lat_reg;
      assign high_time_out[g*`TS_W +: `TS_W] = high_lat_reg;
      assign edge_count_out[g*`CNT_W +: `CNT_W] = count_lat_reg;
      assign analog_out[g*`ADC_W +: `ADC_W] = adc_lat_reg;
    end
  endgenerate
  assign level_out = level_reg;

  // converter words stored at full twelve bits
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (i = 0; i < `N_CHAN; i = i + 1)
        adc_live[i] <= {`ADC_W{1'b0}};
    end
    else if (adc_valid && adc_channel < `N_CHAN)
      adc_live[adc_channel] <= adc_data;
  end
  // straps pulled up read 1; first strap is bit 0
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      {cab1_reg, cab2_reg, cab3_reg, cable_code_reg} <= {(4*`N_CABLE){1'b0}};
    else
    begin
      cab1_reg <= cable_code_inputs;
      cab2_reg <= cab1_reg;
      cab3_reg <= cab2_reg;
      for (i = 0; i < `N_CABLE; i = i + 1)
        if (cab2_reg[i] == cab3_reg[i])
          cable_code_reg[i] <= cab3_reg[i];
    end
  end
  // Board fault pins and configured flag are asynchronous levels
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      {flt1_reg, flt2_reg, flt3_reg, flt_reg} <= 12'h000;
      {cfg1_reg, cfg2_reg, cfg3_reg, cfg_ok_reg} <= 4'h0;
    end
    else
    begin
      flt1_reg <= {wrong_module_type, logic_unprogrammed,
                   over_voltage | over_current};
      flt2_reg <= flt1_reg;
      flt3_reg <= flt2_reg;
      for (i = 0; i < 3; i = i + 1)
        if (flt2_reg[i] == flt3_reg[i])
          flt_reg[i] <= flt3_reg[i];
      cfg1_reg <= config_done;
      cfg2_reg <= cfg1_reg;
      cfg3_reg <= cfg2_reg;
      if (cfg2_reg == cfg3_reg)
        cfg_ok_reg <= cfg3_reg;
    end
  end

  // several rails, bad driver code or bad channel is invalid
  assign cfg_bad = ((cfg_rails & (cfg_rails - {{(`RAIL_W-1){1'b0}}, 1'b1}))
                    != {`RAIL_W{1'b0}}) || (cfg_driver > `DRV_MAX) ||
                   (cfg_channel >= `N_CFG_CHAN);

  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      rail_sel_reg <= {(`N_CFG_CHAN*`RAIL_W){1'b0}};
      driver_sel_reg <= {(`N_CFG_CHAN*`DRV_W){1'b0}};
      {cfg_error_reg, sw_fault_reg, link_up_reg} <= 3'h0;
    end
    else
    begin
      // invalid settings never reach the applied registers
      if (cfg_write && !cfg_bad)
      begin
        rail_sel_reg[cfg_channel*`RAIL_W +: `RAIL_W] <= cfg_rails;
        driver_sel_reg[cfg_channel*`DRV_W +: `DRV_W] <= cfg_driver;
      end
      // one-cycle report back to the model
      cfg_error_reg <= cfg_write & cfg_bad;
      // sticky fault; a new cause beats the clear
      if ((cfg_write && cfg_bad) || model_fault)
        sw_fault_reg <= 1'b1;
      else if (fault_clear)
        sw_fault_reg <= 1'b0;
      // link counts as up once reset by the host while configured
      if (!cfg_ok_reg)
        link_up_reg <= 1'b0;
      else if (link_reset)
        link_up_reg <= 1'b1;
    end
  end

  // any fault source lights the fault LED
  assign fault_any = flt_reg[0] | flt_reg[1] | flt_reg[2] | sw_fault_reg;

  // error code priority, unprogrammed over wrong type over general
  always @*
  begin
    err_code = `ERR_GENERAL;
    blinks = 3'h0;
    if (flt_reg[1])
    begin
      err_code = `ERR_UNPROG;
      blinks = `BLINKS_UNPROG;
    end
    else if (flt_reg[2])
    begin
      err_code = `ERR_WRONG_TYPE;
      blinks = `BLINKS_WRONG_TYPE;
    end
    // Pattern: blinks on/off pairs, then a dark pause
    phase_next = phase_reg + 4'h1;
    if (phase_reg >= {blinks, 1'b0} + `BLINK_PAUSE - 4'h1)
      phase_next = 4'h0;
    blink_on = phase_reg[0] == 1'b0 && phase_reg < {blinks, 1'b0};
  end

  // Blink timer is slow; parameter lets simulation shorten it
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      {blink_cnt_reg, phase_reg} <= 36'h0;
      {led_activity_reg, led_fault_reg} <= 2'h0;
    end
    else
    begin
      if (!fault_any)
      begin
        blink_cnt_reg <= 32'h0;
        phase_reg <= 4'h0;
      end
      else if (blink_cnt_reg >= BLINK_HALF_CYC - 32'h1)
      begin
        blink_cnt_reg <= 32'h0;
        phase_reg <= phase_next;
      end
      else
        blink_cnt_reg <= blink_cnt_reg + 32'h1;
      // fault LED follows the fault sources
      led_fault_reg <= fault_any;
      // steady on for a general error, else blink the code
      if (fault_any)
        led_activity_reg <= (err_code == `ERR_GENERAL) ? 1'b1 : blink_on;
      else
        led_activity_reg <= link_up_reg;
    end
  end

endmodule // pulse_load_channel

// file: pulse_load_channel_asserts.sv
// Purpose: Port checker for pulse_load_channel
// Assumes: One clock, rst async active high
// Notes: Attached by bind at the foot
`timescale 1ns/1ps
`include "pulse_load_defs.vh"
module pulse_load_checker (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Inputs watched
  input wire [`N_CABLE-1:0] cable_code_inputs,
  input wire step_sync,
  input wire cfg_write,
  input wire [`CFG_CH_W-1:0] cfg_channel,
  input wire [`RAIL_W-1:0] cfg_rails,
  input wire [`DRV_W-1:0] cfg_driver,
  input wire over_voltage,
  // Outputs watched
  input wire step_done_reg,
  input wire [`N_CFG_CHAN*`RAIL_W-1:0] rail_sel_reg,
  input wire [`N_CFG_CHAN*`DRV_W-1:0] driver_sel_reg,
  input wire cfg_error_reg,
  input wire sw_fault_reg,
  input wire [`N_CABLE-1:0] cable_code_reg,
  input wire led_activity_reg,
  input wire led_fault_reg
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  bad_driver_a:
    assert property (cfg_write && cfg_driver == 2'h3 |=>
      cfg_error_reg && sw_fault_reg) else $error("Driver 3 taken");
  reject_hold_a:
    assert property (cfg_error_reg |-> $stable(rail_sel_reg) &&
      $stable(driver_sel_reg)) else $error("Bad config applied");
  good_apply_a:
    assert property (cfg_write && cfg_channel == 3'h0 &&
      cfg_driver != 2'h3 && $onehot0(cfg_rails) |=>
      rail_sel_reg[3:0] == $past(cfg_rails)) else $error("Config lost");
  sw_led_a:
    assert property (sw_fault_reg |=> led_fault_reg)
      else $error("Fault LED off");
  pin_led_a:
    assert property (over_voltage [*6] |=> led_fault_reg)
      else $error("Overvoltage unseen");
  cable_follow_a:
    assert property ($stable(cable_code_inputs) [*7] |->
      cable_code_reg == cable_code_inputs) else $error("Cable code");
  step_reply_a:
    assert property ($rose(step_sync) |-> ##[2:6] step_done_reg)
      else $error("Step missed");
  step_single_a:
    assert property (step_done_reg |=> !step_done_reg)
      else $error("Step pulse long");
  cover property (step_done_reg);
  cover property (cfg_error_reg);
  cover property (led_activity_reg && !led_fault_reg);
endmodule // pulse_load_checker

bind pulse_load_channel pulse_load_checker chk (.*);

// file: host_model.sv
// Purpose: Host step unit model: link, config writes, step sync
// Assumes: Tasks are called from the bench one at a time
// Notes: Config lines invert after a write so stale data never helps
`timescale 1ns/1ps
`include "pulse_load_defs.vh"
module host_model (
  // Clock
  input wire ref_clk,
  // Link side
  output reg step_sync,
  output reg config_done,
  output reg link_reset,
  output reg model_fault,
  output reg fault_clear,
  output reg cfg_write,
  output reg [`CFG_CH_W-1:0] cfg_channel,
  output reg [`RAIL_W-1:0] cfg_rails,
  output reg [`DRV_W-1:0] cfg_driver
);
  initial
  begin
    {step_sync, config_done, link_reset, model_fault} = 4'h0;
    {fault_clear, cfg_write, cfg_channel} = 5'h00;
    {cfg_rails, cfg_driver} = 6'h00;
  end
  // Held 6 cycles to cross the synchroniser, then spaced out
  task step;
  begin
    @(posedge ref_clk);
    step_sync <= 1'b1;
    repeat (6) @(posedge ref_clk);
    step_sync <= 1'b0;
    repeat (6) @(posedge ref_clk);
  end
  endtask
  // Strobe 0 link reset, 1 model fault, 2 fault clear
  task strobe(input [1:0] k);
  begin
    @(posedge ref_clk);
    {fault_clear, model_fault, link_reset} <= 3'h1 << k;
    @(posedge ref_clk);
    {fault_clear, model_fault, link_reset} <= 3'h0;
  end
  endtask
  task ready(input v);
  begin
    @(posedge ref_clk);
    config_done <= v;
  end
  endtask
  task write(input [2:0] c, input [3:0] r, input [1:0] d);
  begin
    @(posedge ref_clk);
    cfg_write <= 1'b1;
    {cfg_channel, cfg_rails, cfg_driver} <= {c, r, d};
    @(posedge ref_clk);
    cfg_write <= 1'b0;
    {cfg_channel, cfg_rails, cfg_driver} <= ~{c, r, d};
  end
  endtask
endmodule // host_model

// file: pulse_load_channel_tb.sv
// Purpose: Self-checking bench for pulse_load_channel
// Assumes: Blink half period shortened to 4 cycles
// Notes: Host side comes from host_model, pins are driven here
`timescale 1ns/1ps
`include "pulse_load_defs.vh"
module pulse_load_channel_tb;
  integer num_errors, check_count, n;
  reg ref_clk, rst, adc_valid, over_voltage, over_current;
  reg logic_unprogrammed, wrong_module_type;
  reg [`N_GRP1-1:0] std_group_one_inputs;
  reg [`N_GRP2-1:0] std_group_two_inputs;
  reg [`N_GRP3-1:0] std_group_three_inputs;
  reg [`N_GRP4-1:0] std_group_four_inputs;
  reg [`N_BIP-1:0] bipolar_inputs;
  reg [`N_FLEX-1:0] flex_inputs;
  reg [`N_CABLE-1:0] cable_code_inputs;
  reg [`ADC_CH_W-1:0] adc_channel;
  reg [`ADC_W-1:0] adc_data;
  wire step_sync, config_done, link_reset, model_fault, fault_clear;
  wire cfg_write, step_done_reg, cfg_error_reg, sw_fault_reg;
  wire led_activity_reg, led_fault_reg;
  wire [`CFG_CH_W-1:0] cfg_channel;
  wire [`RAIL_W-1:0] cfg_rails;
  wire [`DRV_W-1:0] cfg_driver;
  wire [`N_CHAN*`TS_W-1:0] period_out, high_time_out;
  wire [`N_CHAN*`CNT_W-1:0] edge_count_out;
  wire [`N_CHAN*`ADC_W-1:0] analog_out;
  wire [`N_CHAN-1:0] level_out;
  wire [`N_CFG_CHAN*`RAIL_W-1:0] rail_sel_reg;
  wire [`N_CFG_CHAN*`DRV_W-1:0] driver_sel_reg;
  wire [`N_CABLE-1:0] cable_code_reg;

  pulse_load_channel #(.BLINK_HALF_CYC(32'h4)) dut (.*);
  host_model host (.*);

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task chk(input [39:0] nm, input [31:0] exp, input [31:0] got);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0s exp %h got %h", nm, exp, got);
    end
  end
  endtask

  task end_sim;
  begin
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  task tick(input integer k);
  begin
    repeat (k) @(posedge ref_clk);
    #1;
  end
  endtask

  task t_cable;
  begin
    @(posedge ref_clk);
    cable_code_inputs <= 5'h16;
    tick(6);
    chk("cable", 32'h16, cable_code_reg);
  end
  endtask

  task t_link;
  begin
    host.strobe(2'h0);
    tick(6);
    chk("act", 32'h0, led_activity_reg);
    host.ready(1'b1);
    tick(5);
    host.strobe(2'h0);
    tick(3);
    chk("act", 32'h1, led_activity_reg);
    host.ready(1'b0);
    tick(6);
    chk("act", 32'h0, led_activity_reg);
  end
  endtask

  task t_cfg;
    integer i;
  begin
    host.write(3'h2, 4'h4, 2'h1);
    tick(1);
    chk("rail", 32'h4, rail_sel_reg[11:8]);
    chk("drv", 32'h1, driver_sel_reg[5:4]);
    host.write(3'h0, 4'h8, 2'h2);
    #1;
    chk("rail", 32'h8, rail_sel_reg[3:0]);
    chk("drv", 32'h2, driver_sel_reg[1:0]);
    // Two rails, driver 3, channel 7 in turn
    for (i = 0; i < 3; i = i + 1)
    begin
      host.write(i == 2 ? 3'h7 : 3'h2, i == 0 ? 4'h3 : 4'h1,
        i == 1 ? 2'h3 : 2'h0);
      // Error flag stands one cycle only
      #1;
      chk("cerr", 32'h1, cfg_error_reg);
      chk("rail", 32'h4, rail_sel_reg[11:8]);
    end
    chk("swf", 32'h1, sw_fault_reg);
    chk("fled", 32'h1, led_fault_reg);
    chk("act", 32'h1, led_activity_reg);
    host.strobe(2'h2);
    tick(3);
    chk("swf", 32'h0, sw_fault_reg);
    host.strobe(2'h1);
    tick(3);
    chk("swf", 32'h1, sw_fault_reg);
    host.strobe(2'h2);
    tick(3);
    chk("fled", 32'h0, led_fault_reg);
  end
  endtask

  task t_meas;
    integer i;
  begin
    host.step;
    @(posedge ref_clk);
    adc_valid <= 1'b1;
    {adc_channel, adc_data} <= {6'h21, 12'hfff};
    // Channel 39 does not exist and must not alias
    @(posedge ref_clk);
    {adc_channel, adc_data} <= {6'h27, 12'h5a5};
    repeat (2)
    begin
      @(posedge ref_clk);
      adc_valid <= 1'b0;
      {std_group_one_inputs[16], std_group_two_inputs[3]} <= 2'h3;
      {std_group_three_inputs[0], std_group_four_inputs[6]} <= 2'h3;
      {bipolar_inputs[1], flex_inputs[4]} <= 2'h3;
      tick(5);
      n = {level_out[38], level_out[33], level_out[31], level_out[21],
        level_out[20], level_out[16], level_out[0]};
      chk("lvl", 32'h7e, n);
      @(posedge ref_clk);
      {std_group_one_inputs[16], std_group_two_inputs[3]} <= 2'h0;
      {std_group_three_inputs[0], std_group_four_inputs[6]} <= 2'h0;
      {bipolar_inputs[1], flex_inputs[4]} <= 2'h0;
      repeat (9) @(posedge ref_clk);
    end
    host.step;
    tick(1);
    for (i = 0; i < 6; i = i + 1)
    begin
      n = i == 0 ? 16 : i == 1 ? 20 : i == 2 ? 21 : i == 3 ? 31 :
        i == 4 ? 33 : 38;
      chk("per", 32'h10, period_out[n*32+:32]);
      chk("high", 32'h6, high_time_out[n*32+:32]);
      chk("edges", 32'h4, edge_count_out[n*16+:16]);
    end
    chk("edges", 32'h0, edge_count_out[15:0]);
    chk("adc", 32'hfff, analog_out[33*12+:12]);
    chk("adc", 32'h0, analog_out[7*12+:12]);
  end
  endtask

  // Blinks between two dark gaps; a steady LED hangs to the watchdog
  task blinks(output integer cnt);
    integer q;
    reg p;
  begin
    cnt = 0;
    q = 0;
    p = 1'b0;
    while (q < 12)
    begin
      tick(1);
      q = led_activity_reg ? 0 : q + 1;
    end
    q = 0;
    while (q < 12)
    begin
      tick(1);
      if (led_activity_reg && !p)
        cnt = cnt + 1;
      p = led_activity_reg;
      q = led_activity_reg ? 0 : q + 1;
    end
  end
  endtask

  task t_blink;
  begin
    @(posedge ref_clk);
    {logic_unprogrammed, wrong_module_type} <= 2'h3;
    blinks(n);
    blinks(n);
    chk("blink", 32'h2, n);
    @(posedge ref_clk);
    logic_unprogrammed <= 1'b0;
    blinks(n);
    blinks(n);
    chk("blink", 32'h3, n);
    @(posedge ref_clk);
    {wrong_module_type, over_current} <= 2'h1;
    tick(8);
    chk("act", 32'h1, led_activity_reg);
    @(posedge ref_clk);
    {over_current, over_voltage} <= 2'h1;
    tick(8);
    chk("fled", 32'h1, led_fault_reg);
    @(posedge ref_clk);
    over_voltage <= 1'b0;
    tick(8);
    chk("fled", 32'h0, led_fault_reg);
  end
  endtask

  initial
  begin
    num_errors = 0;
    check_count = 0;
    rst = 1'b1;
    {std_group_one_inputs, std_group_two_inputs} = 21'h0;
    {std_group_three_inputs, std_group_four_inputs} = 11'h0;
    {bipolar_inputs, flex_inputs, cable_code_inputs} = 12'h0;
    {adc_valid, adc_channel, adc_data} = 19'h0;
    {over_voltage, over_current, logic_unprogrammed} = 3'h0;
    wrong_module_type = 1'b0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    tick(1);
    chk("fled", 32'h0, led_fault_reg);
    t_cable;
    t_link;
    t_cfg;
    t_meas;
    t_blink;
    end_sim;
  end

  // Whole run is well under 2000 cycles
  initial
  begin
    #100000;
    num_errors = num_errors + 1;
    end_sim;
  end
endmodule // pulse_load_channel_tb
